// *** pkg/i2c_mask_pkg.sv ***
`default_nettype none
package i2c_mask_pkg;

   // ==========================================================================
   // Serial framing
   localparam logic [2:0] ADDR_FIXED_BITS = 3'h6;
   localparam logic [3:0] BYTE_BITS = 4'h8;
   localparam logic [3:0] BIT_COUNT_RESET = 4'h0;
   localparam logic DIR_WRITE = 1'b0;

   // ==========================================================================
   // Reset values
   localparam logic [7:0] MASK_RESET = 8'h00;
   localparam logic [7:0] SNAPSHOT_RESET = 8'h00;
   localparam logic [7:0] FLAGS_RESET = 8'h00;
   localparam logic [7:0] SHIFT_RESET = 8'h00;
   localparam logic INT_N_RESET = 1'b1;
   localparam logic [3:0] STRAP_RESET = 4'h0;
   // Idle bus level, so the edge finder sees no false START after reset
   localparam logic [2:0] LINE_IDLE_RESET = 3'h7;

   // ==========================================================================
   // Slave sequencer states
   typedef enum logic [5:0] {
      ST_IDLE = 6'h01,
      ST_ADDR = 6'h02,
      ST_ADDR_ACK = 6'h04,
      ST_DATA = 6'h08,
      ST_DATA_ACK = 6'h10,
      ST_IGNORE = 6'h20
   } slave_state_e;

endpackage
`default_nettype wire

// *** pkg/i2c_bit_if.sv ***
`timescale 1ns/1ps
`default_nettype none
// ==========================================================================
// Bus events found on the sampled lines
interface i2c_bit_if;
   logic scl_rise;
   logic scl_fall;
   logic sda_lvl;
   logic start;
   logic stop;

   modport producer (output scl_rise, output scl_fall, output sda_lvl, output start,
      output stop);
   modport consumer (input scl_rise, input scl_fall, input sda_lvl, input start,
      input stop);
endinterface
`default_nettype wire

// *** design/i2c_line_sync.sv ***
`timescale 1ns/1ps
`default_nettype none
// ==========================================================================
// Line sampler: two flops per line, then a third stage for edge finding
module i2c_line_sync (
   input wire logic mclk_i,
   input wire logic resetn_i,
   input wire logic scl_i,
   input wire logic sda_i,
   i2c_bit_if.producer ev
);
   import i2c_mask_pkg::*;

   logic [2:0] scl_reg;
   logic [2:0] sda_reg;
   logic [2:0] scl_next;
   logic [2:0] sda_next;

   // Shift chain; idle bus is high, so reset to high avoids a false START
   always_comb begin
      scl_next = {scl_reg[1:0], scl_i};
      sda_next = {sda_reg[1:0], sda_i};
   end

   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         scl_reg <= LINE_IDLE_RESET;
         sda_reg <= LINE_IDLE_RESET;
      end else begin
         scl_reg <= scl_next;
         sda_reg <= sda_next;
      end
   end

   // Only stages 1 and 2 are looked at; stage 0 feeds stage 1 alone
   assign ev.scl_rise = scl_reg[1] & ~scl_reg[2];
   assign ev.scl_fall = ~scl_reg[1] & scl_reg[2];
   assign ev.sda_lvl = sda_reg[1];
   assign ev.start = scl_reg[1] & scl_reg[2] & ~sda_reg[1] & sda_reg[2];
   assign ev.stop = scl_reg[1] & scl_reg[2] & sda_reg[1] & ~sda_reg[2];

endmodule // i2c_line_sync
`default_nettype wire

// *** design/i2c_mask_write_path.sv ***
`timescale 1ns/1ps
`default_nettype none
module i2c_mask_write_path (
   input wire logic mclk_i,
   input wire logic resetn_i,
   input wire logic scl_i,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe_o,
   input wire logic [7:0] input_port_pins_i,
   input wire logic [1:0] addr_strap_lo_i,
   input wire logic [1:0] addr_strap_hi_i,
   output logic int_n_o,
   output logic [7:0] int_mask_o,
   output logic [7:0] port_snapshot_o,
   output logic [7:0] transition_flags_o
);
   import i2c_mask_pkg::*;

   // ==========================================================================
   // Line sampling
   i2c_bit_if ev ();

   i2c_line_sync u_sync (
      .mclk_i(mclk_i),
      .resetn_i(resetn_i),
      .scl_i(scl_i),
      .sda_i(sda_i),
      .ev(ev)
   );

   // Ports and straps come from outside, so two flops before any use
   logic [7:0] pins_s1_reg;
   logic [7:0] pins_reg;
   logic [3:0] strap_s1_reg;
   logic [3:0] strap_reg;

   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         pins_s1_reg <= SNAPSHOT_RESET;
         pins_reg <= SNAPSHOT_RESET;
         strap_s1_reg <= STRAP_RESET;
         strap_reg <= STRAP_RESET;
      end else begin
         pins_s1_reg <= input_port_pins_i;
         pins_reg <= pins_s1_reg;
         strap_s1_reg <= {addr_strap_hi_i, addr_strap_lo_i};
         strap_reg <= strap_s1_reg;
      end
   end

   // ==========================================================================
   // Address decode
   // Each strap is four-level; its two-bit code forms two address bits
   function automatic logic addr_match(input logic [7:0] frame, input logic [3:0] strap);
      addr_match = (frame[7:5] == ADDR_FIXED_BITS) && (frame[4:1] == strap);
   endfunction

   // ==========================================================================
   // Slave sequencer
   slave_state_e state_reg;
   slave_state_e state_next;
   logic [3:0] cnt_reg;
   logic [3:0] cnt_next;
   logic [7:0] shift_reg;
   logic [7:0] shift_next;
   logic [7:0] mask_reg;
   logic [7:0] mask_next;
   logic [7:0] snap_reg;
   logic [7:0] snap_next;
   logic [7:0] flags_reg;
   logic [7:0] flags_next;
   logic int_n_reg;
   logic int_n_next;
   logic byte_end;
   logic take_snap;

   // A byte is complete on the falling edge after the eighth rising edge
   assign byte_end = ev.scl_fall && (cnt_reg == BYTE_BITS);
   // Ports are sampled on the address acknowledge clock's rising edge
   assign take_snap = (state_reg == ST_ADDR_ACK) && ev.scl_rise;

   // Next-state logic; START and STOP override any bit in flight
   always_comb begin
      state_next = state_reg;
      cnt_next = cnt_reg;
      shift_next = shift_reg;
      mask_next = mask_reg;
      if (ev.start) begin
         state_next = ST_ADDR;
         cnt_next = BIT_COUNT_RESET;
      end else if (ev.stop) begin
         state_next = ST_IDLE;
         cnt_next = BIT_COUNT_RESET;
      end else begin
         unique case (state_reg)
            ST_IDLE, ST_IGNORE: begin
               cnt_next = BIT_COUNT_RESET;
            end
            ST_ADDR: begin
               if (ev.scl_rise) begin
                  shift_next = {shift_reg[6:0], ev.sda_lvl};
                  cnt_next = cnt_reg + 4'h1;
               end else if (byte_end) begin
                  cnt_next = BIT_COUNT_RESET;
                  // Reads belong to another path, so they are not answered
                  if (addr_match(shift_reg, strap_reg) && shift_reg[0] == DIR_WRITE) begin
                     state_next = ST_ADDR_ACK;
                  end else begin
                     state_next = ST_IGNORE;
                  end
               end
            end
            ST_DATA: begin
               if (ev.scl_rise) begin
                  shift_next = {shift_reg[6:0], ev.sda_lvl};
                  cnt_next = cnt_reg + 4'h1;
               end else if (byte_end) begin
                  cnt_next = BIT_COUNT_RESET;
                  mask_next = shift_reg;
                  state_next = ST_DATA_ACK;
               end
            end
            ST_ADDR_ACK, ST_DATA_ACK: begin
               // Acknowledge held until the ninth clock falls
               if (ev.scl_fall) begin
                  state_next = ST_DATA;
               end
            end
         endcase
      end
   end

   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         state_reg <= ST_IDLE;
         cnt_reg <= BIT_COUNT_RESET;
         shift_reg <= SHIFT_RESET;
         mask_reg <= MASK_RESET;
      end else begin
         state_reg <= state_next;
         cnt_reg <= cnt_next;
         shift_reg <= shift_next;
         mask_reg <= mask_next;
      end
   end

   // ==========================================================================
   // Transition flags and interrupt
   // Flags compare against the last snapshot; a fresh snapshot equals the
   // pins, so clearing and a same-cycle change cannot lose an event later
   always_comb begin
      snap_next = snap_reg;
      flags_next = flags_reg | (pins_reg ^ snap_reg);
      if (take_snap) begin
         snap_next = pins_reg;
         flags_next = FLAGS_RESET;
      end
      int_n_next = ~|(flags_next & mask_next);
   end

   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         snap_reg <= SNAPSHOT_RESET;
         flags_reg <= FLAGS_RESET;
         int_n_reg <= INT_N_RESET;
      end else begin
         snap_reg <= snap_next;
         flags_reg <= flags_next;
         int_n_reg <= int_n_next;
      end
   end

   // ==========================================================================
   // Outputs
   // Open drain: only ever pulls low, enable marks the acknowledge
   assign sda_o = 1'b0;
   assign sda_oe_o = (state_reg == ST_ADDR_ACK) || (state_reg == ST_DATA_ACK);
   assign int_n_o = int_n_reg;
   assign int_mask_o = mask_reg;
   assign port_snapshot_o = snap_reg;
   assign transition_flags_o = flags_reg;

   // ==========================================================================
   // Checks
   default clocking cb @(posedge mclk_i);
   endclocking
   default disable iff (!resetn_i);

   addr_ack_drive_a: assert property (
      byte_end && !ev.start && !ev.stop && state_reg == ST_ADDR
         && addr_match(shift_reg, strap_reg) && !shift_reg[0]
      |=> sda_oe_o && state_reg == ST_ADDR_ACK)
      else $error("address not acknowledged");

   snap_capture_a: assert property (
      take_snap && !ev.start && !ev.stop |=> port_snapshot_o == $past(pins_reg))
      else $error("snapshot not taken at acknowledge");

   int_release_a: assert property (
      take_snap && !ev.start && !ev.stop |=> int_n_o)
      else $error("interrupt not released at address acknowledge");

   data_ack_a: assert property (
      byte_end && !ev.start && !ev.stop && state_reg == ST_DATA
      |=> sda_oe_o ##1 (sda_oe_o || state_reg == ST_DATA || state_reg == ST_IDLE
         || state_reg == ST_ADDR))
      else $error("data byte not acknowledged");

   mask_load_a: assert property (
      byte_end && !ev.start && !ev.stop && state_reg == ST_DATA
      |=> int_mask_o == $past(shift_reg))
      else $error("mask not loaded from byte");

   flags_clear_a: assert property (
      take_snap && !ev.start && !ev.stop |=> transition_flags_o == 8'h00)
      else $error("flags not cleared by write");

   mask_gate_a: assert property (
      int_n_o == ~|(transition_flags_o & int_mask_o))
      else $error("interrupt not gated by mask");

   addr_fixed_a: assert property (
      byte_end && state_reg == ST_ADDR && shift_reg[7:5] != ADDR_FIXED_BITS |=> !sda_oe_o)
      else $error("foreign address acknowledged");

   read_dir_a: assert property (
      byte_end && state_reg == ST_ADDR && shift_reg[0] |=> !sda_oe_o)
      else $error("read direction acknowledged by write path");

endmodule // i2c_mask_write_path
`default_nettype wire

// *** testbench/i2c_master_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// ==========================================================================
// Bus master: drives SCL high and low, pulls SDA low; SDA has a pull-up
module i2c_master_model (
   input wire logic sda_i,
   output logic scl_o,
   output logic sda_low_o
);
   localparam real QTR = 31.25;
   // Idle bus: SCL driven high, SDA released so its pull-up holds it high
   initial begin
      scl_o = 1'b1;
      sda_low_o = 1'b0;
   end
   // SDA falls while SCL is high
   task automatic start_cond();
      #QTR sda_low_o = 1'b1;
      #QTR scl_o = 1'b0;
   endtask
   // Repeated START: SDA let go in the low phase, then falls while SCL is high
   task automatic restart_cond();
      #QTR sda_low_o = 1'b0;
      #QTR scl_o = 1'b1;
      #QTR sda_low_o = 1'b1;
      #QTR scl_o = 1'b0;
   endtask
   // Data moves mid low phase so it is stable around both SCL edges
   task automatic clock_bit(input logic b, output logic seen);
      #QTR sda_low_o = ~b;
      #QTR scl_o = 1'b1;
      #QTR seen = sda_i;
      #QTR scl_o = 1'b0;
   endtask
   // MSB first, then SDA released for the ninth bit
   task automatic send_byte(input logic [7:0] data, output logic ack);
      logic seen;
      for (int i = 7; i >= 0; i--) begin
         clock_bit(data[i], seen);
      end
      clock_bit(1'b1, seen);
      ack = ~seen;
   endtask
   // SDA rises while SCL is high; SCL then stands still
   task automatic stop_cond();
      #QTR sda_low_o = 1'b1;
      #QTR scl_o = 1'b1;
      #QTR sda_low_o = 1'b0;
      #QTR;
   endtask
endmodule // i2c_master_model
`default_nettype wire

// *** testbench/i2c_mask_write_path_tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
`define CHECK(got, want) begin \
   checks_done++; \
   if ((got) !== (want)) begin \
      failures++; \
      $display("mismatch at %0t: got %h want %h", $time, got, want); \
   end \
end
module i2c_mask_write_path_tb_top;
   import i2c_mask_pkg::*;
   logic mclk_i, resetn_i, scl, sda_low, sda_line, sda_o, sda_oe_o, int_n_o;
   logic [7:0] pins, int_mask_o, port_snapshot_o, transition_flags_o;
   logic [1:0] strap_lo, strap_hi;
   int failures = 0;
   int checks_done = 0;
   // ==========================================================================
   // Wired-AND SDA with pull-up
   assign sda_line = ~(sda_low | (sda_oe_o & ~sda_o));
   i2c_master_model bus (.sda_i(sda_line), .scl_o(scl), .sda_low_o(sda_low));
   i2c_mask_write_path DUT (.mclk_i(mclk_i), .resetn_i(resetn_i), .scl_i(scl),
      .sda_i(sda_line), .sda_o(sda_o), .sda_oe_o(sda_oe_o), .input_port_pins_i(pins),
      .addr_strap_lo_i(strap_lo), .addr_strap_hi_i(strap_hi), .int_n_o(int_n_o),
      .int_mask_o(int_mask_o), .port_snapshot_o(port_snapshot_o),
      .transition_flags_o(transition_flags_o));
   // ==========================================================================
   // Helpers
   task automatic give_verdict();
      if (failures == 0 && checks_done > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   function automatic logic [7:0] addr_of(input logic rw);
      return {3'h6, strap_hi, strap_lo, rw};
   endfunction
   // Whole frame; start is offset from mclk edges to avoid sampling races
   task automatic do_write(input logic [7:0] addr, input logic [7:0] d0, input int n,
      input logic exp_ack);
      logic ack;
      logic [7:0] keep;
      @(posedge mclk_i);
      #2;
      keep = int_mask_o;
      bus.start_cond();
      bus.send_byte(addr, ack);
      `CHECK(ack, exp_ack)
      if (exp_ack) begin
         `CHECK(int_n_o, 1'b1)
         `CHECK(port_snapshot_o, pins)
         `CHECK(transition_flags_o, 8'h00)
         for (int k = 0; k < n; k++) begin
            bus.send_byte(d0 + 8'(k * 8'h11), ack);
            `CHECK(ack, 1'b1)
            `CHECK(int_mask_o, d0 + 8'(k * 8'h11))
         end
      end
      bus.stop_cond();
      if (!exp_ack) `CHECK(int_mask_o, keep)
   endtask
   // ==========================================================================
   // Scenarios
   task automatic strap_sweep();
      for (int i = 0; i < 4; i++) begin
         @(posedge mclk_i);
         strap_lo <= 2'(i);
         strap_hi <= 2'(3 - i);
         pins <= 8'h5a ^ 8'(i);
         repeat (4) @(posedge mclk_i);
         do_write(addr_of(1'b0), 8'h10 + 8'(i), 1, 1'b1);
      end
   endtask
   task automatic multi_write();
      do_write(addr_of(1'b0), 8'h81, 3, 1'b1);
      `CHECK(int_mask_o, 8'ha3)
   endtask
   task automatic mask_gate();
      do_write(addr_of(1'b0), 8'h01, 1, 1'b1);
      @(posedge mclk_i);
      pins <= pins ^ 8'h02;
      repeat (6) @(posedge mclk_i);
      #1;
      `CHECK(transition_flags_o, 8'h02)
      `CHECK(int_n_o, 1'b1)
      @(posedge mclk_i);
      pins <= pins ^ 8'h03;
      repeat (6) @(posedge mclk_i);
      #1;
      `CHECK(transition_flags_o, 8'h03)
      `CHECK(int_n_o, 1'b0)
      do_write(addr_of(1'b0), 8'h02, 1, 1'b1);
      `CHECK(int_n_o, 1'b1)
   endtask
   // Repeated START after a refused read, then a cut byte before STOP
   task automatic restart_abort();
      logic ack;
      logic seen;
      @(posedge mclk_i);
      #2;
      bus.start_cond();
      bus.send_byte(addr_of(1'b1), ack);
      `CHECK(ack, 1'b0)
      bus.restart_cond();
      bus.send_byte(addr_of(1'b0), ack);
      `CHECK(ack, 1'b1)
      bus.send_byte(8'h3c, ack);
      `CHECK(ack, 1'b1)
      for (int i = 0; i < 4; i++) begin
         bus.clock_bit(1'b1, seen);
      end
      bus.stop_cond();
      `CHECK(int_mask_o, 8'h3c)
   endtask
   // Reset in the middle of a data byte clears the interface and the mask
   task automatic reset_mid();
      logic ack;
      logic seen;
      @(posedge mclk_i);
      #2;
      bus.start_cond();
      bus.send_byte(addr_of(1'b0), ack);
      for (int i = 0; i < 3; i++) begin
         bus.clock_bit(1'b0, seen);
      end
      @(posedge mclk_i);
      resetn_i <= 1'b0;
      repeat (2) @(posedge mclk_i);
      #1;
      `CHECK(sda_oe_o, 1'b0)
      `CHECK(int_n_o, 1'b1)
      `CHECK(int_mask_o, MASK_RESET)
      @(posedge mclk_i);
      resetn_i <= 1'b1;
      repeat (4) @(posedge mclk_i);
      #2;
      bus.stop_cond();
      do_write(addr_of(1'b0), 8'h44, 1, 1'b1);
   endtask
   task automatic refusals();
      do_write({3'h7, strap_hi, strap_lo, 1'b0}, 8'h00, 1, 1'b0);
      do_write({3'h6, ~strap_hi, strap_lo, 1'b0}, 8'h00, 1, 1'b0);
      do_write(addr_of(1'b1), 8'h00, 1, 1'b0);
   endtask
   // ==========================================================================
   // Clock, reset, sequence and hang guard
   initial begin
      mclk_i = 1'b0;
      forever #5 mclk_i = ~mclk_i;
   end
   initial begin
      resetn_i = 1'b0;
      pins = 8'h00;
      strap_lo = 2'h0;
      strap_hi = 2'h0;
      repeat (8) @(posedge mclk_i);
      resetn_i <= 1'b1;
      repeat (4) @(posedge mclk_i);
      #1;
      `CHECK(int_mask_o, 8'h00)
      strap_sweep();
      multi_write();
      mask_gate();
      restart_abort();
      reset_mid();
      refusals();
      give_verdict();
   end
   initial begin
      repeat (100000) @(posedge mclk_i);
      failures++;
      $display("mismatch at %0t: run too long", $time);
      give_verdict();
   end
endmodule // i2c_mask_write_path_tb_top
`default_nettype wire
